// file: hdl/dmp_param_bank.sv
// dmp_param_bank: monitoring parameter bank answering modbus rtu requests
// How it works
// - exception reply carries function code plus 80h
// - unsupported function code gives exception 01
// - invalid register address gives exception 02
// - out-of-range written value gives exception 03
// - read-only or run-locked write gives exception 04
// - display selections accept only 0 to 11
// - selection codes name the monitored quantity
// - reset selections are 4 and 5
// - fault clear 0-10, value 1 clears fault
// - rated voltage and current read-only factory values
// - duty type read-only, 0 torque 1 fan
// - frequency standard read-only, reset 0
// - four fault entries, dash when empty
// - firmware revision read-only in hundredths
// - run seconds and total hours counters
// - speed display equals speed times coefficient divided by 1000
// - boot selection 0-10 is stored and read back only, first display code is 0
// - switching key steps through selected quantities
// - parameter number equals holding register address
// - crc-16 from ffff, low byte first
module dmp_param_bank
  import dmp_pkg::*;
#(
  parameter int SEC_COUNT = SEC_CYCLES,
  parameter logic [15:0] RATED_VOLT = 16'h017c,
  parameter logic [15:0] RATED_CURR = 16'h000a,
  parameter logic [15:0] DUTY_TYPE = 16'h0000,
  parameter logic [15:0] FREQ_STD = FREQ_STD_RST,
  parameter logic [15:0] FW_REV = 16'h0064
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] slaveAddr,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  input wire logic rxFrameEnd,
  input wire logic txReady,
  input wire logic driveRunning,
  input wire logic faultEvent,
  input wire logic [15:0] faultCode,
  input wire logic switchKey,
  input wire logic [15:0] speedActual,
  input wire logic [15:0] monitorValue,
  output logic [7:0] txByte,
  output logic txValid,
  output logic faultActive,
  output logic faultClearPulse,
  output logic [15:0] displayCode,
  output logic [15:0] displayValue
);
  dmp_bank_t st_r;
  dmp_bank_t st_nxt;
  logic [15:0] memData;
  logic [1:0] memRdAddr;
  logic [7:0] reqFc;
  logic [15:0] reqAdr;
  logic [15:0] reqVal;
  logic [7:0] excNow;
  logic isRead;
  logic isData;
  logic [7:0] txNow;
  logic [15:0] scaled;
  logic [4:0] histK;

  // ****************************************************************
  // register decode
  // ****************************************************************
  function automatic logic [15:0] regValue(input dmp_bank_t s, input logic [15:0] hist);
    logic [15:0] adr;
    logic [4:0] k;
    adr = ADR_DISP1 + {11'h000, s.regIdx};
    k = s.regIdx - OFS_HIST;
    regValue = 16'h0000;
    if (adr == ADR_DISP1) begin
      regValue = s.disp1;
    end else if (adr == ADR_DISP2) begin
      regValue = s.disp2;
    end else if (adr == ADR_CLEAR) begin
      regValue = s.clearCmd;
    end else if (adr == ADR_VOLT) begin
      regValue = RATED_VOLT;
    end else if (adr == ADR_CURR) begin
      regValue = RATED_CURR;
    end else if (adr == ADR_DUTY) begin
      regValue = DUTY_TYPE;
    end else if (adr == ADR_FREQ) begin
      regValue = FREQ_STD;
    end else if (adr >= ADR_HIST1 && adr <= ADR_HIST4) begin
      regValue = ({2'b00, k[2:0]} < {2'b00, s.histCnt}) ? hist : FAULT_NONE;
    end else if (adr == ADR_FWREV) begin
      regValue = FW_REV;
    end else if (adr == ADR_SEC) begin
      regValue = s.runSec;
    end else if (adr == ADR_HOURS) begin
      regValue = s.runHrs;
    end else if (adr == ADR_SCALE) begin
      regValue = s.scale;
    end else if (adr == ADR_BOOT) begin
      regValue = s.boot;
    end
  endfunction : regValue

  // single register write check, returns the exception code
  function automatic logic [7:0] writeCheck(input logic [15:0] adr, input logic [15:0] val,
                                            input logic run);
    if (adr < ADR_DISP1 || adr > ADR_BOOT) begin
      writeCheck = EXC_ADDR;
    end else if (adr == ADR_DISP1 || adr == ADR_DISP2) begin
      writeCheck = run ? EXC_FAIL : ((val > DISP_MAX) ? EXC_RANGE : EXC_NONE);
    end else if (adr == ADR_CLEAR) begin
      writeCheck = (val > CLEAR_MAX) ? EXC_RANGE : EXC_NONE;
    end else if (adr == ADR_SCALE) begin
      writeCheck = (val > SCALE_MAX) ? EXC_RANGE : EXC_NONE;
    end else if (adr == ADR_BOOT) begin
      writeCheck = (val > BOOT_MAX) ? EXC_RANGE : EXC_NONE;
    end else begin
      writeCheck = EXC_FAIL;
    end
  endfunction : writeCheck

  // ****************************************************************
  // fault history store
  // ****************************************************************
  assign histK = st_r.regIdx - OFS_HIST;
  // newest record is entry one
  assign memRdAddr = st_r.wrPtr - 2'h1 - histK[1:0];

  dmp_fault_mem u_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .wrEn(faultEvent),
    .wrAddr(st_r.wrPtr),
    .wrData(faultCode),
    .rdAddr(memRdAddr),
    .rdData(memData)
  );

  // ****************************************************************
  // request decode and reply byte
  // ****************************************************************
  assign reqFc = st_r.rxBuf[1];
  assign reqAdr = {st_r.rxBuf[2], st_r.rxBuf[3]};
  assign reqVal = {st_r.rxBuf[4], st_r.rxBuf[5]};
  assign isRead = (reqFc == FC_READ);
  assign isData = isRead && (st_r.excCode == EXC_NONE) && (st_r.txIdx >= 6'h03)
                  && (st_r.txIdx < st_r.txLen - 6'h02);
  assign scaled = 16'(({16'h0000, speedActual} * {16'h0000, st_r.scale}) / SCALE_ONE);

  always_comb begin
    excNow = EXC_NONE;
    if (reqFc != FC_READ && reqFc != FC_WRITE) begin
      excNow = EXC_FUNC;
    end else if (isRead) begin
      if (reqVal == 16'h0000 || reqVal > MAX_QTY) begin
        excNow = EXC_RANGE;
      end else if (reqAdr < ADR_DISP1
                   || ({1'b0, reqAdr} + {1'b0, reqVal}) > ({1'b0, ADR_BOOT} + 17'h00001)) begin
        excNow = EXC_ADDR;
      end
    end else begin
      excNow = writeCheck(reqAdr, reqVal, driveRunning);
    end
  end

  always_comb begin
    txNow = 8'h00;
    if (st_r.txIdx == st_r.txLen - 6'h02) begin
      txNow = st_r.txCrc[7:0];
    end else if (st_r.txIdx == st_r.txLen - 6'h01) begin
      txNow = st_r.txCrc[15:8];
    end else if (st_r.txIdx == 6'h00) begin
      txNow = st_r.rxBuf[0];
    end else if (st_r.txIdx == 6'h01) begin
      txNow = (st_r.excCode != EXC_NONE) ? (reqFc | EXC_FLAG) : reqFc;
    end else if (st_r.excCode != EXC_NONE) begin
      txNow = st_r.excCode;
    end else if (isRead) begin
      if (st_r.txIdx == 6'h02) begin
        txNow = {reqVal[6:0], 1'b0};
      end else begin
        txNow = st_r.txIdx[0] ? st_r.word[15:8] : st_r.word[7:0];
      end
    end else begin
      txNow = st_r.rxBuf[st_r.txIdx[2:0]];
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.clearPulse = 1'b0;
    case (st_r.fsm)
      ST_RECV: begin
        if (rxValid) begin
          if (st_r.rxCnt < RX_LEN) begin
            st_nxt.rxBuf[st_r.rxCnt[2:0]] = rxByte;
          end
          if (st_r.rxCnt != 4'hf) begin
            st_nxt.rxCnt = st_r.rxCnt + 4'h1;
          end
          st_nxt.rxCrc = crcByte(st_r.rxCrc, rxByte);
        end else if (rxFrameEnd) begin
          st_nxt.rxCnt = 4'h0;
          st_nxt.rxCrc = CRC_INIT;
          if (st_r.rxCnt >= MIN_LEN && st_r.rxCrc == 16'h0000
              && (st_r.rxBuf[0] == slaveAddr || st_r.rxBuf[0] == 8'h00)
              && (st_r.rxCnt == RX_LEN || (reqFc != FC_READ && reqFc != FC_WRITE))) begin
            st_nxt.fsm = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        st_nxt.excCode = excNow;
        st_nxt.txIdx = 6'h00;
        st_nxt.txCrc = CRC_INIT;
        st_nxt.haveWord = 1'b0;
        st_nxt.regIdx = 5'(reqAdr - ADR_DISP1);
        if (excNow != EXC_NONE) begin
          st_nxt.txLen = EXC_LEN;
        end else if (isRead) begin
          st_nxt.txLen = RD_OVER + {reqVal[4:0], 1'b0};
        end else begin
          st_nxt.txLen = WR_LEN;
          if (reqAdr == ADR_DISP1) begin
            st_nxt.disp1 = reqVal;
          end else if (reqAdr == ADR_DISP2) begin
            st_nxt.disp2 = reqVal;
          end else if (reqAdr == ADR_CLEAR) begin
            st_nxt.clearCmd = reqVal;
            if (reqVal == CLEAR_CMD) begin
              st_nxt.faultActive = 1'b0;
              st_nxt.clearPulse = 1'b1;
            end
          end else if (reqAdr == ADR_SCALE) begin
            st_nxt.scale = reqVal;
          end else if (reqAdr == ADR_BOOT) begin
            st_nxt.boot = reqVal;
          end
        end
        st_nxt.fsm = (st_r.rxBuf[0] == 8'h00) ? ST_RECV : ST_SEND;
      end
      ST_FETCH: begin
        st_nxt.fsm = ST_GRAB;
      end
      ST_GRAB: begin
        st_nxt.word = regValue(st_r, memData);
        st_nxt.regIdx = st_r.regIdx + 5'h01;
        st_nxt.haveWord = 1'b1;
        st_nxt.fsm = ST_SEND;
      end
      ST_SEND: begin
        if (st_r.txValid) begin
          if (txReady) begin
            st_nxt.txValid = 1'b0;
          end
        end else if (st_r.txIdx == st_r.txLen) begin
          st_nxt.fsm = ST_RECV;
        end else if (isData && st_r.txIdx[0] && !st_r.haveWord) begin
          st_nxt.fsm = ST_FETCH;
        end else begin
          st_nxt.txByte = txNow;
          st_nxt.txValid = 1'b1;
          st_nxt.txIdx = st_r.txIdx + 6'h01;
          if (st_r.txIdx < st_r.txLen - 6'h02) begin
            st_nxt.txCrc = crcByte(st_r.txCrc, txNow);
          end
          if (isData && !st_r.txIdx[0]) begin
            st_nxt.haveWord = 1'b0;
          end
        end
      end
      default: begin
        st_nxt.fsm = ST_RECV;
      end
    endcase

    // a new fault wins over a clear in the same cycle
    if (faultEvent) begin
      st_nxt.faultActive = 1'b1;
      st_nxt.wrPtr = st_r.wrPtr + 2'h1;
      if (st_r.histCnt != 3'h4) begin
        st_nxt.histCnt = st_r.histCnt + 3'h1;
      end
    end

    if (driveRunning) begin
      if (st_r.tickCnt == 32'(SEC_COUNT - 1)) begin
        st_nxt.tickCnt = 32'h00000000;
        if (st_r.runSec == SEC_MAX) begin
          st_nxt.runSec = 16'h0000;
          if (st_r.runHrs != HOUR_MAX) begin
            st_nxt.runHrs = st_r.runHrs + 16'h0001;
          end
        end else begin
          st_nxt.runSec = st_r.runSec + 16'h0001;
        end
      end else begin
        st_nxt.tickCnt = st_r.tickCnt + 32'h00000001;
      end
    end

    if (switchKey) begin
      st_nxt.dispSlot = ~st_r.dispSlot;
      st_nxt.dispCode = st_r.dispSlot ? st_r.disp1 : st_r.disp2;
    end
    if (st_r.dispCode == SPEED_CODE) begin
      st_nxt.dispValue = scaled;
    end else if (st_r.dispCode == NONE_CODE) begin
      st_nxt.dispValue = 16'h0000;
    end else begin
      st_nxt.dispValue = monitorValue;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= BANK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txByte = st_r.txByte;
  assign txValid = st_r.txValid;
  assign faultActive = st_r.faultActive;
  assign faultClearPulse = st_r.clearPulse;
  assign displayCode = st_r.dispCode;
  assign displayValue = st_r.dispValue;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_exc_fcode:
  assert property (@(posedge sys_clk) disable iff (rst)
    st_r.txValid && st_r.txIdx == 6'h02 && st_r.excCode != EXC_NONE
    |-> st_r.txByte == (reqFc | EXC_FLAG))
    else $error("exception function code wrong");

  a_exc_unsup:
  assert property (@(posedge sys_clk) disable iff (rst)
    st_r.fsm == ST_EXEC && reqFc != FC_READ && reqFc != FC_WRITE |=> st_r.excCode == EXC_FUNC)
    else $error("unsupported function not flagged");

  a_exc_addr:
  assert property (@(posedge sys_clk) disable iff (rst)
    st_r.fsm == ST_EXEC && reqFc == FC_WRITE && reqAdr > ADR_BOOT |=> st_r.excCode == EXC_ADDR)
    else $error("bad address not flagged");

  a_exc_range:
  assert property (@(posedge sys_clk) disable iff (rst)
    st_r.fsm == ST_EXEC && reqFc == FC_WRITE && reqAdr == ADR_BOOT && reqVal > BOOT_MAX
    |=> st_r.excCode == EXC_RANGE && st_r.boot == $past(st_r.boot))
    else $error("out of range write not refused");

  a_exc_ro:
  assert property (@(posedge sys_clk) disable iff (rst)
    st_r.fsm == ST_EXEC && reqFc == FC_WRITE && reqAdr == ADR_VOLT
    |=> st_r.excCode == EXC_FAIL && st_r.txLen == EXC_LEN)
    else $error("read-only write not refused");

  a_disp_limit:
  assert property (@(posedge sys_clk) disable iff (rst)
    st_r.disp1 <= DISP_MAX && st_r.disp2 <= DISP_MAX)
    else $error("display selection out of range");

  a_clear_fault:
  assert property (@(posedge sys_clk) disable iff (rst)
    st_r.fsm == ST_EXEC && excNow == EXC_NONE && reqFc == FC_WRITE && reqAdr == ADR_CLEAR
    && reqVal == CLEAR_CMD && !faultEvent |=> !st_r.faultActive && st_r.clearPulse)
    else $error("fault clear not applied");

  a_sec_wrap:
  assert property (@(posedge sys_clk) disable iff (rst)
    driveRunning && st_r.tickCnt == 32'(SEC_COUNT - 1) && st_r.runSec == SEC_MAX
    |=> st_r.runSec == 16'h0000)
    else $error("run seconds did not wrap");

  a_speed_show:
  assert property (@(posedge sys_clk) disable iff (rst)
    st_r.dispCode == SPEED_CODE |=> st_r.dispValue == $past(scaled))
    else $error("speed display not scaled");

  a_crc_start:
  assert property (@(posedge sys_clk) disable iff (rst)
    st_r.fsm == ST_EXEC |=> st_r.txCrc == CRC_INIT && st_r.txIdx == 6'h00)
    else $error("reply crc not seeded");
endmodule : dmp_param_bank

// file: hdl/dmp_pkg.sv
// dmp_pkg: constants, types and helpers of the drive monitoring parameter bank
package dmp_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // holding register addresses
  // ****************************************************************
  localparam logic [15:0] ADR_DISP1 = 16'h00aa;
  localparam logic [15:0] ADR_DISP2 = 16'h00ab;
  localparam logic [15:0] ADR_CLEAR = 16'h00ac;
  localparam logic [15:0] ADR_VOLT = 16'h00ad;
  localparam logic [15:0] ADR_CURR = 16'h00ae;
  localparam logic [15:0] ADR_DUTY = 16'h00af;
  localparam logic [15:0] ADR_FREQ = 16'h00b0;
  localparam logic [15:0] ADR_HIST1 = 16'h00b1;
  localparam logic [15:0] ADR_HIST2 = 16'h00b2;
  localparam logic [15:0] ADR_HIST3 = 16'h00b3;
  localparam logic [15:0] ADR_HIST4 = 16'h00b4;
  localparam logic [15:0] ADR_FWREV = 16'h00b5;
  localparam logic [15:0] ADR_SEC = 16'h00b6;
  localparam logic [15:0] ADR_HOURS = 16'h00b7;
  localparam logic [15:0] ADR_SCALE = 16'h00b8;
  localparam logic [15:0] ADR_BOOT = 16'h00b9;
  localparam logic [4:0] OFS_HIST = 5'(ADR_HIST1 - ADR_DISP1);

  // ****************************************************************
  // function and exception codes
  // ****************************************************************
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_RANGE = 8'h03;
  localparam logic [7:0] EXC_FAIL = 8'h04;

  // ****************************************************************
  // reset values, limits and codes
  // ****************************************************************
  localparam logic [15:0] DISP1_RST = 16'h0004;
  localparam logic [15:0] DISP2_RST = 16'h0005;
  localparam logic [15:0] CLEAR_RST = 16'h0000;
  localparam logic [15:0] FREQ_STD_RST = 16'h0000;
  localparam logic [15:0] SCALE_RST = 16'h03e8;
  localparam logic [15:0] BOOT_RST = 16'h0000;
  localparam logic [15:0] DISP_MAX = 16'h000b;
  localparam logic [15:0] CLEAR_MAX = 16'h000a;
  localparam logic [15:0] CLEAR_CMD = 16'h0001;
  localparam logic [15:0] SCALE_MAX = 16'h270f;
  localparam logic [15:0] BOOT_MAX = 16'h000a;
  localparam logic [15:0] SEC_MAX = 16'h0e0f;
  localparam logic [15:0] HOUR_MAX = 16'hffff;
  localparam logic [15:0] SPEED_CODE = 16'h0002;
  localparam logic [15:0] NONE_CODE = 16'h0000;
  localparam logic [15:0] FAULT_NONE = 16'h2d2d;
  localparam logic [15:0] MAX_QTY = 16'h0010;
  localparam logic [31:0] SCALE_ONE = {16'h0000, SCALE_RST};
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [3:0] RX_LEN = 4'h8;
  localparam logic [3:0] MIN_LEN = 4'h4;
  localparam logic [5:0] EXC_LEN = 6'h05;
  localparam logic [5:0] WR_LEN = 6'h08;
  localparam logic [5:0] RD_OVER = 6'h05;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_RECV = 5'h01,
    ST_EXEC = 5'h02,
    ST_FETCH = 5'h04,
    ST_GRAB = 5'h08,
    ST_SEND = 5'h10
  } dmp_fsm_t;

  typedef struct packed {
    dmp_fsm_t fsm;
    logic [7:0][7:0] rxBuf;
    logic [3:0] rxCnt;
    logic [15:0] rxCrc;
    logic [15:0] txCrc;
    logic [5:0] txIdx;
    logic [5:0] txLen;
    logic [7:0] txByte;
    logic txValid;
    logic [7:0] excCode;
    logic [15:0] word;
    logic haveWord;
    logic [4:0] regIdx;
    logic [15:0] disp1;
    logic [15:0] disp2;
    logic [15:0] clearCmd;
    logic [15:0] scale;
    logic [15:0] boot;
    logic faultActive;
    logic clearPulse;
    logic [31:0] tickCnt;
    logic [15:0] runSec;
    logic [15:0] runHrs;
    logic dispSlot;
    logic [15:0] dispCode;
    logic [15:0] dispValue;
    logic [1:0] wrPtr;
    logic [2:0] histCnt;
  } dmp_bank_t;

  typedef struct packed {
    logic [3:0][15:0] words;
    logic [15:0] rdData;
  } dmp_mem_t;

  localparam dmp_bank_t BANK_RST = '{fsm: ST_RECV, rxCrc: CRC_INIT, txCrc: CRC_INIT,
    disp1: DISP1_RST, disp2: DISP2_RST, clearCmd: CLEAR_RST, scale: SCALE_RST,
    boot: BOOT_RST, dispSlot: 1'b1, dispCode: BOOT_RST, default: '0};

  // crc-16 over one byte, reflected polynomial
  function automatic logic [15:0] crcByte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crcByte = c;
  endfunction : crcByte
endpackage : dmp_pkg

// file: hdl/dmp_fault_mem.sv
// dmp_fault_mem: four-entry fault record store with registered read data
module dmp_fault_mem
  import dmp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [1:0] wrAddr,
  input wire logic [15:0] wrData,
  input wire logic [1:0] rdAddr,
  output logic [15:0] rdData
);
  dmp_mem_t st_r;
  dmp_mem_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wrEn) begin
      st_nxt.words[wrAddr] = wrData;
    end
    st_nxt.rdData = st_r.words[rdAddr];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rdData;
endmodule : dmp_fault_mem

// file: tb/dmp_master.sv
// dmp_master: rtu master model sending request frames and collecting replies
module dmp_master
  import dmp_pkg::*;
(
  input wire logic sys_clk,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic rxFrameEnd,
  output logic txReady,
  input wire logic [7:0] txByte,
  input wire logic txValid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rsp[$];
  logic [1:0] stall = 2'h0;
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
    rxFrameEnd = 1'b0;
    txReady = 1'b0;
  end
  // ****************************************************************
  // reply sink, stalls one cycle in three
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (txValid && txReady) rsp.push_back(txByte);
    stall <= (stall == 2'h2) ? 2'h0 : stall + 2'h1;
    txReady <= (stall != 2'h2);
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  task automatic sendFrame(input logic [7:0] req[$]);
    logic [15:0] c;
    c = crc16(req);
    req.push_back(c[7:0]);
    req.push_back(c[15:8]);
    rsp.delete();
    foreach (req[i]) begin
      @(posedge sys_clk);
      rxByte <= req[i];
      rxValid <= 1'b1;
    end
    @(posedge sys_clk);
    rxValid <= 1'b0;
    rxByte <= ~rxByte;
    rxFrameEnd <= 1'b1;
    @(posedge sys_clk);
    rxFrameEnd <= 1'b0;
  endtask : sendFrame
endmodule : dmp_master

// file: tb/tb_top.sv
// tb_top: self-checking bench of the monitoring parameter bank
module tb_top;
  import dmp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] dmp_bq_t[$];
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic driveRunning = 1'b0;
  logic faultEvent = 1'b0;
  logic switchKey = 1'b0;
  logic [15:0] faultCode = 16'h0000;
  logic [15:0] speedActual = 16'h0000;
  logic [15:0] monitorValue = 16'h0000;
  logic [7:0] rxByte;
  logic [7:0] txByte;
  logic rxValid;
  logic rxFrameEnd;
  logic txReady;
  logic txValid;
  logic faultActive;
  logic faultClearPulse;
  logic [15:0] displayCode;
  logic [15:0] displayValue;
  logic sawClr = 1'b0;
  int seed = 47221;
  int mismatches = 0;
  int n_compared = 0;
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (faultClearPulse) sawClr <= 1'b1;
  end
  dmp_param_bank #(.SEC_COUNT(10)) i_dmp_param_bank (.sys_clk(sys_clk), .rst(rst),
    .slaveAddr(8'h11), .rxByte(rxByte), .rxValid(rxValid), .rxFrameEnd(rxFrameEnd),
    .txReady(txReady), .driveRunning(driveRunning), .faultEvent(faultEvent),
    .faultCode(faultCode), .switchKey(switchKey), .speedActual(speedActual),
    .monitorValue(monitorValue), .txByte(txByte), .txValid(txValid),
    .faultActive(faultActive), .faultClearPulse(faultClearPulse),
    .displayCode(displayCode), .displayValue(displayValue));
  dmp_master i_dmp_master (.sys_clk(sys_clk), .rxByte(rxByte), .rxValid(rxValid),
    .rxFrameEnd(rxFrameEnd), .txReady(txReady), .txByte(txByte), .txValid(txValid));
  function automatic dmp_bq_t pdu(logic [7:0] fc, logic [15:0] a, logic [15:0] v);
    return '{8'h11, fc, a[15:8], a[7:0], v[15:8], v[7:0]};
  endfunction : pdu
  task automatic xfer(input dmp_bq_t req, input dmp_bq_t exp);
    logic [15:0] c;
    c = i_dmp_master.crc16(exp);
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    i_dmp_master.sendFrame(req);
    repeat (600) if (i_dmp_master.rsp.size() < exp.size()) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    `CHK(i_dmp_master.rsp.size(), exp.size())
    foreach (exp[i]) `CHK(i_dmp_master.rsp[i], exp[i])
  endtask : xfer
  task automatic key();
    @(posedge sys_clk);
    switchKey <= 1'b1;
    @(posedge sys_clk);
    switchKey <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : key
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #300us;
    mismatches++;
    final_report();
  end
  initial begin
    dmp_bq_t e;
    logic [31:0] t;
    logic [15:0] v;
    logic [15:0] rv [16] = '{16'h4, 16'h5, 16'h0, 16'h17c, 16'ha, 16'h0, 16'h0, 16'h2d2d,
      16'h2d2d, 16'h2d2d, 16'h2d2d, 16'h64, 16'h0, 16'h0, 16'h3e8, 16'h0};
    logic [31:0] exc [8] = '{32'h04aa0101, 32'h03a00102, 32'h06aa0c03, 32'h06ad0104,
      32'h06b00004, 32'h06ac0b03, 32'h06b90b03, 32'h06aa0304};
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    e = '{8'h11, 8'h03, 8'h20};
    foreach (rv[i]) e = {e, rv[i][15:8], rv[i][7:0]};
    xfer(pdu(8'h03, 16'h00aa, 16'h0010), e);
    $display("test reset_values done");
    foreach (exc[i]) begin
      t = exc[i];
      driveRunning <= (i == 7);
      xfer(pdu(t[31:24], {8'h00, t[23:16]}, {8'h00, t[15:8]}),
        '{8'h11, t[31:24] | 8'h80, t[7:0]});
    end
    driveRunning <= 1'b0;
    $display("test exceptions done");
    // 100 running cycles are exactly ten counter periods, whatever the phase
    i_dmp_master.sendFrame(pdu(8'h03, 16'h00b6, 16'h0001));
    repeat (40) @(posedge sys_clk);
    t = {16'h0000, i_dmp_master.rsp[3], i_dmp_master.rsp[4]};
    driveRunning <= 1'b1;
    repeat (100) @(posedge sys_clk);
    driveRunning <= 1'b0;
    v = t[15:0] + 16'h000a;
    xfer(pdu(8'h03, 16'h00b6, 16'h0001), '{8'h11, 8'h03, 8'h02, v[15:8], v[7:0]});
    $display("test run_time done");
    repeat (6) begin
      v = 16'($unsigned($random(seed)) % 12);
      xfer(pdu(8'h06, 16'h00aa, v), pdu(8'h06, 16'h00aa, v));
      xfer(pdu(8'h03, 16'h00aa, 16'h0001), '{8'h11, 8'h03, 8'h02, v[15:8], v[7:0]});
    end
    v = 16'($unsigned($random(seed)) % 10000);
    xfer(pdu(8'h06, 16'h00b8, v), pdu(8'h06, 16'h00b8, v));
    xfer(pdu(8'h06, 16'h00aa, 16'h0002), pdu(8'h06, 16'h00aa, 16'h0002));
    speedActual <= 16'($random(seed));
    monitorValue <= 16'($random(seed));
    repeat (2) if (displayCode !== 16'h0002) key();
    `CHK(displayCode, 16'h0002)
    `CHK(displayValue, 16'((32'(speedActual) * 32'(v)) / 1000))
    key();
    `CHK(displayCode, 16'h0005)
    `CHK(displayValue, monitorValue)
    $display("test display done");
    faultCode <= 16'($random(seed));
    faultEvent <= 1'b1;
    @(posedge sys_clk);
    faultEvent <= 1'b0;
    @(posedge sys_clk);
    `CHK(faultActive, 1'b1)
    xfer(pdu(8'h03, 16'h00b1, 16'h0001),
      '{8'h11, 8'h03, 8'h02, faultCode[15:8], faultCode[7:0]});
    xfer(pdu(8'h06, 16'h00ac, 16'h0001), pdu(8'h06, 16'h00ac, 16'h0001));
    `CHK(sawClr, 1'b1)
    `CHK(faultActive, 1'b0)
    $display("test fault done");
    final_report();
  end
endmodule : tb_top
